// ===== rtl/cps_pkg.sv
// package: register map, field layout and carriers of the port statistics block
package cps_pkg;
  // ==========================================================================
  // register offsets
  localparam logic [7:0] CPS_PORT_SEL_OFS   = 8'h4c;
  localparam logic [7:0] CPS_FALL_MASK_OFS  = 8'h7f;
  localparam logic [7:0] CPS_FALL_STS_OFS   = 8'h7c;
  localparam logic [7:0] CPS_FRAME_HI_OFS   = 8'h90;
  localparam logic [7:0] CPS_FRAME_LO_OFS   = 8'h91;
  localparam logic [7:0] CPS_FERR_HI_OFS    = 8'h92;
  localparam logic [7:0] CPS_FERR_LO_OFS    = 8'h93;
  localparam logic [7:0] CPS_LINE_HI_OFS    = 8'h94;
  localparam logic [7:0] CPS_LINE_LO_OFS    = 8'h95;
  localparam logic [7:0] CPS_LERR_HI_OFS    = 8'h96;
  localparam logic [7:0] CPS_LERR_LO_OFS    = 8'h97;
  // ==========================================================================
  // reset values and field layout
  localparam logic [7:0]  CPS_MASK_RST      = 8'h00;
  localparam logic [15:0] CPS_CNT_RST       = 16'h0000;
  localparam logic [7:0]  CPS_SNAP_RST      = 8'h00;
  localparam int          CPS_CNT_HI_MSB    = 15;
  localparam int          CPS_CNT_HI_LSB    = 8;
  localparam int          CPS_NUM_CNT       = 4;
  localparam int          CPS_PSEL_W        = 2;
  // ==========================================================================
  // serial control bus register access after byte decode
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cps_reg_req_t;
  // count events of the output port, one bit per counter
  typedef struct packed {
    logic lerr;
    logic line;
    logic ferr;
    logic frame;
  } cps_cnt_evt_t;
endpackage : cps_pkg

// ===== rtl/cps_port_stats.sv
// status and statistics register group of the deserializer hub output port
// Function
// - eight-bit falling-edge mask per receive port
// - masked falling status bit raises latched interrupt
// - port-select register picks mask copy accessed
// - frame high read returns msbs, snapshots, clears
// - frame low returns snapshot; high first
// - errored-frame high read: msbs, snapshot, clear
// - errored-frame low returns snapshot; high first
// - line high read: msbs, snapshot, clear
// - line low returns snapshot; high first
// - errored-line high read: msbs, snapshot, clear
// - errored-line low returns snapshot; high first
// - counters, snapshots and masks reset zero
module cps_port_stats
  import cps_pkg::*;
#(
  parameter int NUM_PORTS = 4
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  // register access from the serial control bus
  input  wire cps_reg_req_t         req_i,
  output logic [7:0]                rdata_o,
  output logic                      rvalid_o,
  // receive port sensor status bytes
  input  wire logic [NUM_PORTS*8-1:0] sensor_status_byte_i,
  // output port count events
  input  wire cps_cnt_evt_t         evt_i,
  // interrupt
  output logic                      sensor_fall_irq_o
);
  // ==========================================================================
  // elaboration check
  if (NUM_PORTS < 1 || NUM_PORTS > 4) begin : g_bad_ports
    $error("NUM_PORTS must lie in 1..4");
  end

  // address match, used for writes, the status read and the high reads
  function automatic logic hit(input cps_reg_req_t r, input logic [7:0] ofs);
    return r.addr == ofs;
  endfunction

  logic [7:0]  port_sel_q;
  logic [7:0]  mask_q    [NUM_PORTS];
  logic [7:0]  fall_sts_q[NUM_PORTS];
  logic [7:0]  prev_sts_q[NUM_PORTS];
  logic [NUM_PORTS-1:0] port_irq;
  logic [CPS_NUM_CNT-1:0] hi_rd;
  logic [CPS_NUM_CNT-1:0] inc;
  logic [15:0] cnt  [CPS_NUM_CNT];
  logic [7:0]  snap [CPS_NUM_CNT];
  logic [7:0]  rdata_d;
  logic [7:0]  sel_mask;
  logic [7:0]  sel_sts;
  logic [CPS_PSEL_W-1:0] sel_idx;
  logic        irq_d;

  // ==========================================================================
  // port select
  // low bits choose the receive port copy
  assign sel_idx  = port_sel_q[CPS_PSEL_W-1:0];
  assign sel_mask = (int'(sel_idx) < NUM_PORTS) ? mask_q[sel_idx] : 8'h00;
  assign sel_sts  = (int'(sel_idx) < NUM_PORTS) ? fall_sts_q[sel_idx] : 8'h00;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      port_sel_q <= 8'h00;
    end else if (req_i.wr && hit(req_i, CPS_PORT_SEL_OFS)) begin
      port_sel_q <= req_i.wdata;
    end
  end

  // ==========================================================================
  // per port mask, edge detect and sticky status
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic       sel_p;
    logic [7:0] fall;
    assign sel_p = (int'(sel_idx) == p);
    assign fall  = prev_sts_q[p] & ~sensor_status_byte_i[p*8 +: 8] & mask_q[p];
    assign port_irq[p] = |fall_sts_q[p];

    always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
        mask_q[p]     <= CPS_MASK_RST;
        fall_sts_q[p] <= 8'h00;
        prev_sts_q[p] <= 8'h00;
      end else begin
        prev_sts_q[p] <= sensor_status_byte_i[p*8 +: 8];
        if (sel_p && req_i.wr && hit(req_i, CPS_FALL_MASK_OFS)) begin
          mask_q[p] <= req_i.wdata;
        end
        // latch event; set wins over read clear
        if (sel_p && req_i.rd && hit(req_i, CPS_FALL_STS_OFS)) begin
          fall_sts_q[p] <= fall;
        end else begin
          fall_sts_q[p] <= fall_sts_q[p] | fall;
        end
      end
    end
  end

  // ==========================================================================
  // statistics counters of the output port
  assign inc = {evt_i.lerr, evt_i.line, evt_i.ferr, evt_i.frame};
  assign hi_rd = {req_i.rd && hit(req_i, CPS_LERR_HI_OFS),
                  req_i.rd && hit(req_i, CPS_LINE_HI_OFS),
                  req_i.rd && hit(req_i, CPS_FERR_HI_OFS),
                  req_i.rd && hit(req_i, CPS_FRAME_HI_OFS)};

  for (genvar c = 0; c < CPS_NUM_CNT; c++) begin : g_cnt
    cps_stat_counter u_cnt (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .inc_i     (inc[c]),
      .hi_rd_i   (hi_rd[c]),
      .count_o   (cnt[c]),
      .snap_o    (snap[c])
    );
  end

  // ==========================================================================
  // read data mux; unmapped offsets read zero
  always_comb begin
    rdata_d = 8'h00;
    unique case (req_i.addr)
      CPS_PORT_SEL_OFS:  rdata_d = port_sel_q;
      CPS_FALL_MASK_OFS: rdata_d = sel_mask;
      CPS_FALL_STS_OFS:  rdata_d = sel_sts;
      CPS_FRAME_HI_OFS:  rdata_d = cnt[0][CPS_CNT_HI_MSB:CPS_CNT_HI_LSB];
      CPS_FRAME_LO_OFS:  rdata_d = snap[0];
      CPS_FERR_HI_OFS:   rdata_d = cnt[1][CPS_CNT_HI_MSB:CPS_CNT_HI_LSB];
      CPS_FERR_LO_OFS:   rdata_d = snap[1];
      CPS_LINE_HI_OFS:   rdata_d = cnt[2][CPS_CNT_HI_MSB:CPS_CNT_HI_LSB];
      CPS_LINE_LO_OFS:   rdata_d = snap[2];
      CPS_LERR_HI_OFS:   rdata_d = cnt[3][CPS_CNT_HI_MSB:CPS_CNT_HI_LSB];
      CPS_LERR_LO_OFS:   rdata_d = snap[3];
      default:           rdata_d = 8'h00;
    endcase
  end

  // registered outputs; irq follows sticky status one cycle later
  assign irq_d = |port_irq;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_o           <= 8'h00;
      rvalid_o          <= 1'b0;
      sensor_fall_irq_o <= 1'b0;
    end else begin
      rdata_o           <= req_i.rd ? rdata_d : 8'h00;
      rvalid_o          <= req_i.rd;
      sensor_fall_irq_o <= irq_d;
    end
  end

  // ==========================================================================
  // assertions
  a_frame_hi_data : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.rd && req_i.addr == CPS_FRAME_HI_OFS) |=> rvalid_o && rdata_o == $past(cnt[0][15:8]))
    else $error("frame high read data wrong");
  a_frame_lo_snap : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.rd && req_i.addr == CPS_FRAME_HI_OFS) ##1 (req_i.rd && req_i.addr == CPS_FRAME_LO_OFS)
    |=> rdata_o == $past(cnt[0][7:0], 2))
    else $error("frame low snapshot wrong");
  a_ferr_clear : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.rd && req_i.addr == CPS_FERR_HI_OFS && !evt_i.ferr) |=> cnt[1] == 16'h0000)
    else $error("errored frame counter not cleared");
  a_ferr_lo_snap : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.rd && req_i.addr == CPS_FERR_HI_OFS) |=> snap[1] == $past(cnt[1][7:0]))
    else $error("errored frame snapshot wrong");
  a_line_clear : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.rd && req_i.addr == CPS_LINE_HI_OFS && !evt_i.line) |=> cnt[2] == 16'h0000)
    else $error("line counter not cleared");
  a_line_lo_snap : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.rd && req_i.addr == CPS_LINE_HI_OFS) |=> snap[2] == $past(cnt[2][7:0]))
    else $error("line snapshot wrong");
  a_lerr_clear : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.rd && req_i.addr == CPS_LERR_HI_OFS && !evt_i.lerr) |=> cnt[3] == 16'h0000)
    else $error("errored line counter not cleared");
  a_lerr_lo_snap : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.rd && req_i.addr == CPS_LERR_HI_OFS) |=> snap[3] == $past(cnt[3][7:0]))
    else $error("errored line snapshot wrong");
  a_fall_irq_rise : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ((prev_sts_q[0] & ~sensor_status_byte_i[7:0] & mask_q[0]) != 8'h00)
    |=> ##1 sensor_fall_irq_o)
    else $error("masked fall did not raise interrupt");
  a_fall_latch : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ((prev_sts_q[0] & ~sensor_status_byte_i[7:0] & mask_q[0]) != 8'h00)
    |=> fall_sts_q[0] != 8'h00)
    else $error("masked fall not latched in status");
  a_mask_wr : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.wr && req_i.addr == CPS_FALL_MASK_OFS && sel_idx == 2'd0)
    |=> mask_q[0] == $past(req_i.wdata))
    else $error("mask write to selected port lost");
  a_mask_keep : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.wr && req_i.addr == CPS_FALL_MASK_OFS && sel_idx != 2'd0) |=> $stable(mask_q[0]))
    else $error("mask write reached an unselected port");
  a_mask_rd : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.rd && req_i.addr == CPS_FALL_MASK_OFS && sel_idx == 2'd0)
    |=> rdata_o == $past(mask_q[0]))
    else $error("mask read of selected port wrong");
  a_rd_idle_zero : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !req_i.rd |=> !rvalid_o && rdata_o == 8'h00)
    else $error("read answer without a read");
  a_count_up : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (evt_i.frame && !hi_rd[0]) |=> cnt[0] == $past(cnt[0]) + 16'h0001)
    else $error("frame event not counted");

  c_fall_irq  : cover property (@(posedge clk_i) $rose(sensor_fall_irq_o));
  c_hi_lo     : cover property (@(posedge clk_i) hi_rd[0] ##1 (req_i.rd && req_i.addr == CPS_FRAME_LO_OFS));
  c_clr_event : cover property (@(posedge clk_i) hi_rd[2] && evt_i.line);
  c_port_sel  : cover property (@(posedge clk_i) req_i.wr && req_i.addr == CPS_PORT_SEL_OFS);
endmodule // cps_port_stats

// ===== rtl/cps_stat_counter.sv
// one 16-bit read-to-clear statistics counter with low byte snapshot
module cps_stat_counter
  import cps_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // count and access
  input  wire logic        inc_i,
  input  wire logic        hi_rd_i,
  // state
  output logic [15:0]      count_o,
  output logic [7:0]       snap_o
);
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [7:0]  snap_q;
  logic [7:0]  snap_d;

  // ==========================================================================
  // next values
  // wrap and clear-then-count: event on clear leaves one
  assign count_d = hi_rd_i ? {15'h0, inc_i} : count_q + {15'h0, inc_i};
  // snapshot low byte on high read
  assign snap_d  = hi_rd_i ? count_q[7:0] : snap_q;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      count_q <= CPS_CNT_RST;
      snap_q  <= CPS_SNAP_RST;
    end else begin
      count_q <= count_d;
      snap_q  <= snap_d;
    end
  end

  assign count_o = count_q;
  assign snap_o  = snap_q;

  a_hi_rd_clear : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    hi_rd_i |=> (snap_q == $past(count_q[7:0])) && (count_q == {15'h0, $past(inc_i)}))
    else $error("high read did not clear and snapshot");
  a_cnt_wrap : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (count_q == 16'hffff && inc_i && !hi_rd_i) |=> count_q == 16'h0000)
    else $error("counter failed to wrap");
endmodule // cps_stat_counter

// ===== test/cps_port_stats_tb_top.sv
// self-checking bench of the port statistics register group
module cps_port_stats_tb_top
  import cps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // signals
  logic                clk_i = 1'b0;
  logic                reset_n_i = 1'b0;
  cps_reg_req_t        req_i = '0;
  logic [31:0]         sensor_status_byte_i = '0;
  cps_cnt_evt_t        evt_i = '0;
  logic [7:0]          rdata_o;
  logic                rvalid_o;
  logic                sensor_fall_irq_o;
  logic [7:0]          exp_q[$];
  logic [15:0]         c[4];
  logic [7:0]          m[4];
  logic [31:0]         lfsr = 32'h2d441158;
  int                  mismatches = 0;
  int                  n_checks = 0;

  cps_port_stats #(.NUM_PORTS(4)) u_cps_port_stats (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .sensor_status_byte_i(sensor_status_byte_i),
    .evt_i(evt_i), .sensor_fall_irq_o(sensor_fall_irq_o));

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;
  // ==========================================================================
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // wait edges, then step off the edge before driving
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // the request stands until the next access or idle replaces it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req_i = {2'b01, a, d};
    evt_i = '0;
    cycles(1);
  endtask

  // note the expected byte, then issue the read with optional count events
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [3:0] ev);
    exp_q.push_back(e);
    req_i = {2'b10, a, 8'h00};
    evt_i = ev;
    cycles(1);
  endtask

  // drop the bus for a cycle; a held read would otherwise repeat
  task automatic idle;
    req_i = '0;
    evt_i = '0;
    cycles(1);
  endtask

  task automatic read_counters;
    logic [7:0] s;
    logic [7:0] hi;
    for (int k = 0; k < 4; k++) begin
      hi = 8'h90 + 8'(2 * k);
      s = c[k][7:0];
      rd(hi, c[k][15:8], 4'(1 << k));
      rd(hi + 8'h01, s, 4'h0);
      rd(hi, 8'h00, 4'h0);
      rd(hi + 8'h01, 8'h01, 4'h0);
      c[k] = '0;
    end
  endtask
  // ==========================================================================
  // read monitor: oldest note against each returned byte
  logic [7:0]          exp_v;
  always @(posedge clk_i) begin
    if (rvalid_o === 1'b1) begin
      exp_v = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hxx;
      check("rdata", rdata_o, exp_v);
    end
  end

  // watchdog sized above the 66k-cycle wrap run
  initial begin
    repeat (80000) @(posedge clk_i);
    mismatches++;
    end_of_test;
  end
  // ==========================================================================
  // main sequence
  initial begin
    #1;
    cycles(2);
    reset_n_i = 1'b1;
    // reset values; read-only write and unmapped read give zero
    wr(CPS_FRAME_LO_OFS, 8'hff);
    rd(8'h10, 8'h00, 4'h0);
    rd(CPS_FALL_MASK_OFS, 8'h00, 4'h0);
    for (int a = 8'h90; a < 8'h98; a++) rd(8'(a), 8'h00, 4'h0);
    // falls with clear masks stay silent
    idle;
    sensor_status_byte_i = '1;
    cycles(2);
    sensor_status_byte_i = '0;
    cycles(3);
    check("irq masked", 8'(sensor_fall_irq_o), 8'h00);
    sensor_status_byte_i = '1;
    cycles(2);
    // separate mask copy per selected port
    for (int p = 0; p < 4; p++) begin
      lfsr = lfsr_next(lfsr);
      m[p] = lfsr[7:0] | 8'h01;
      wr(CPS_PORT_SEL_OFS, 8'(p));
      wr(CPS_FALL_MASK_OFS, m[p]);
    end
    for (int p = 0; p < 4; p++) begin
      wr(CPS_PORT_SEL_OFS, 8'(p));
      rd(CPS_FALL_MASK_OFS, m[p], 4'h0);
    end
    // masked falls on every port latch and raise the interrupt
    idle;
    sensor_status_byte_i = '0;
    cycles(3);
    check("irq raised", 8'(sensor_fall_irq_o), 8'h01);
    for (int p = 0; p < 4; p++) begin
      wr(CPS_PORT_SEL_OFS, 8'(p));
      rd(CPS_FALL_STS_OFS, m[p], 4'h0);
    end
    idle;
    cycles(2);
    check("irq cleared", 8'(sensor_fall_irq_o), 8'h00);
    rd(CPS_FALL_STS_OFS, 8'h00, 4'h0);
    idle;
    // random count events, enough to reach the high byte
    repeat (700) begin
      lfsr = lfsr_next(lfsr);
      evt_i = lfsr[3:0];
      for (int k = 0; k < 4; k++) c[k] += 16'(evt_i[k]);
      cycles(1);
    end
    read_counters;
    idle;
    evt_i = '1;
    cycles(65541);
    for (int k = 0; k < 4; k++) c[k] = 16'(65541);
    read_counters;
    idle;
    cycles(2);
    check("pending reads", 8'(exp_q.size()), 8'h00);
    end_of_test;
  end
endmodule // cps_port_stats_tb_top
